// ### hdl/gs_pwm_pkg.sv
// Constants shared by the grayscale PWM channel block
package gs_pwm_pkg;

  // ****************************************
  // Channel and packet geometry
  // ****************************************
  localparam int NUM_CH       = 16;
  localparam int GS_W         = 12;
  localparam int GS_PKT_W     = 192;
  localparam int DC_PKT_W     = 96;
  localparam int OPEN_LSB     = 176;
  localparam int OVERTEMP_BIT = 175;
  localparam int CORR_LSB     = 72;
  localparam int CORR_MSB     = 167;
  localparam logic [GS_W-1:0] GS_ZERO = 12'h000;
  localparam logic [GS_W-1:0] GS_MAX  = 12'hFFF;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ        = 40;
  localparam int ON_SETTLE_NS   = 1000;
  localparam int ON_SETTLE_CYC  = (ON_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_W       = 6;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(ON_SETTLE_CYC - 1);

  // ****************************************
  // Synchronised pin positions
  // ****************************************
  localparam int PIN_SCLK     = 0;
  localparam int PIN_SIN      = 1;
  localparam int PIN_LATCH    = 2;
  localparam int PIN_PROG     = 3;
  localparam int PIN_CSRC     = 4;
  localparam int PIN_GRAYSCALE_COUNT_CLOCK    = 5;
  localparam int PIN_INH      = 6;
  localparam int PIN_OTEMP    = 7;
  localparam int PIN_OPEN_LSB = 8;
  localparam int PIN_COUNT    = 24;

  // ****************************************
  // Register bus map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;
  localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_NVCORR0 = 8'h04;
  localparam logic [ADDR_W-1:0] REG_NVCORR1 = 8'h08;
  localparam logic [ADDR_W-1:0] REG_NVCORR2 = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_CORR0   = 8'h10;
  localparam logic [ADDR_W-1:0] REG_CORR1   = 8'h14;
  localparam logic [ADDR_W-1:0] REG_CORR2   = 8'h18;
  localparam int NVCORR_WORDS = 3;
  localparam logic [DATA_W-1:0] NVCORR_RST = 32'h0000_0000;

  // Status register fields
  localparam int ST_CNT_LSB  = 0;
  localparam int ST_OTEMP    = 12;
  localparam int ST_MODE     = 13;
  localparam int ST_PENDING  = 14;
  localparam int ST_OPEN_LSB = 16;

endpackage : gs_pwm_pkg

// ### hdl/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/10ps
module pin_sync
#(
  parameter int WIDTH = 1
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] meta;

  // ****************************************
  // Per-bit synchroniser
  // ****************************************
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        meta[i]         <= 1'b0;
        pin_sync_out[i] <= 1'b0;
      end
      else
      begin
        meta[i]         <= pin_in[i];
        pin_sync_out[i] <= meta[i];
      end
    end
  end

endmodule : pin_sync

// ### hdl/grayscale_pwm_led_channels.sv
// Sixteen-channel grayscale PWM engine with serial packet input and status readback
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/10ps
module grayscale_pwm_led_channels
(
  // Clock and reset
  input  wire logic                              REF_CLK,
  input  wire logic                              RST_N,
  // Avalon-MM slave
  input  wire logic [gs_pwm_pkg::ADDR_W-1:0]     AVS_ADDRESS,
  input  wire logic                              AVS_READ,
  input  wire logic                              AVS_WRITE,
  input  wire logic [gs_pwm_pkg::BE_W-1:0]       AVS_BYTEENABLE,
  input  wire logic [gs_pwm_pkg::DATA_W-1:0]     AVS_WRITEDATA,
  output logic      [gs_pwm_pkg::DATA_W-1:0]     AVS_READDATA,
  output logic                                   AVS_WAITREQUEST,
  // Serial link pins
  input  wire logic                              SERIAL_SHIFT_CLOCK,
  input  wire logic                              SERIAL_INPUT_PIN,
  input  wire logic                              LATCH_STROBE,
  output logic                                   SERIAL_OUTPUT_PIN,
  // Mode pins
  input  wire logic                              PROGRAM_SELECT_PIN,
  input  wire logic                              CORRECTION_SOURCE_SELECT,
  // PWM pins
  input  wire logic                              GRAYSCALE_COUNT_CLOCK,
  input  wire logic                              OUTPUT_INHIBIT,
  output logic      [gs_pwm_pkg::NUM_CH-1:0]     SINK_CHANNEL,
  // Analog sense inputs
  input  wire logic [gs_pwm_pkg::NUM_CH-1:0]     OPEN_SENSE,
  input  wire logic                              OVERTEMP_SENSE
);
  import gs_pwm_pkg::*;

  logic [PIN_COUNT-1:0]          pins_s;
  logic [PIN_COUNT-1:0]          pins_prev;
  logic                          sclk_rise;
  logic                          latch_rise;
  logic                          grayscale_count_clock_rise;
  logic                          sin_s;
  logic                          prog_s;
  logic                          csrc_s;
  logic                          inh_s;
  logic                          overtemp_flag;
  logic [NUM_CH-1:0]             open_s;
  logic [GS_PKT_W-1:0]           shift_reg;
  logic [GS_PKT_W-1:0]           gs_input;
  logic [GS_PKT_W-1:0]           gs_active;
  logic [DC_PKT_W-1:0]           corr_reg;
  logic [NVCORR_WORDS-1:0][DATA_W-1:0] nv_corr;
  logic [GS_PKT_W-1:0]           status_info_word;
  logic                          need_extra;
  logic                          gs_pending;
  logic [GS_W-1:0]               gs_count;
  logic [NUM_CH-1:0]             ch_on;
  logic [NUM_CH-1:0]             gs_zero;
  logic [NUM_CH-1:0]             open_led_flag;
  logic                          resp;
  logic                          wr_take;
  logic                          open_clr;
  logic [DATA_W-1:0]             next_readdata;

  // ****************************************
  // Pin synchronisation and edge detection
  // ****************************************
  pin_sync #(.WIDTH(PIN_COUNT)) u_pin_sync
  (
    .clk          (REF_CLK),
    .rst_n        (RST_N),
    .pin_in       ({OPEN_SENSE, OVERTEMP_SENSE, OUTPUT_INHIBIT, GRAYSCALE_COUNT_CLOCK,
                    CORRECTION_SOURCE_SELECT, PROGRAM_SELECT_PIN, LATCH_STROBE,
                    SERIAL_INPUT_PIN, SERIAL_SHIFT_CLOCK}),
    .pin_sync_out (pins_s)
  );

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      pins_prev <= '0;
    else
      pins_prev <= pins_s;
  end

  assign sclk_rise     = pins_s[PIN_SCLK] & ~pins_prev[PIN_SCLK];
  assign latch_rise    = pins_s[PIN_LATCH] & ~pins_prev[PIN_LATCH];
  assign grayscale_count_clock_rise    = pins_s[PIN_GRAYSCALE_COUNT_CLOCK] & ~pins_prev[PIN_GRAYSCALE_COUNT_CLOCK];
  assign sin_s         = pins_s[PIN_SIN];
  assign prog_s        = pins_s[PIN_PROG];
  assign csrc_s        = pins_s[PIN_CSRC];
  assign inh_s         = pins_s[PIN_INH];
  assign overtemp_flag = pins_s[PIN_OTEMP];
  assign open_s        = pins_s[PIN_OPEN_LSB +: NUM_CH];

  // ****************************************
  // Status word assembly
  // ****************************************
  always_comb
  begin
    status_info_word                        = '0;
    status_info_word[OPEN_LSB +: NUM_CH]    = open_led_flag;
    status_info_word[OVERTEMP_BIT]          = overtemp_flag;
    status_info_word[CORR_MSB:CORR_LSB]     = csrc_s ? corr_reg : nv_corr;
  end

  // ****************************************
  // Input shift register
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      shift_reg <= '0;
    else if (latch_rise)
    begin
      if (!prog_s)
        shift_reg <= status_info_word;
    end
    else if (sclk_rise)
    begin
      if (prog_s)
        shift_reg[DC_PKT_W-1:0] <= {shift_reg[DC_PKT_W-2:0], sin_s};
      else
        shift_reg <= {shift_reg[GS_PKT_W-2:0], sin_s};
    end
  end

  // Serial output follows the top bit of the active register length
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      SERIAL_OUTPUT_PIN <= 1'b0;
    else
      SERIAL_OUTPUT_PIN <= prog_s ? shift_reg[DC_PKT_W-1] : shift_reg[GS_PKT_W-1];
  end

  // ****************************************
  // Grayscale and correction latches
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      gs_input   <= '0;
      gs_active  <= '0;
      gs_pending <= 1'b0;
      need_extra <= 1'b0;
      corr_reg   <= '0;
    end
    else if (latch_rise)
    begin
      if (prog_s)
      begin
        corr_reg   <= shift_reg[DC_PKT_W-1:0];
        need_extra <= 1'b1;
      end
      else
      begin
        gs_input   <= shift_reg;
        need_extra <= 1'b0;
        if (need_extra)
          gs_pending <= 1'b1;
        else
          gs_active <= shift_reg;
      end
    end
    else if (sclk_rise && gs_pending)
    begin
      gs_active  <= gs_input;
      gs_pending <= 1'b0;
    end
  end

  // ****************************************
  // Grayscale counter
  // ****************************************
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      gs_count <= GS_ZERO;
    else if (inh_s)
      gs_count <= GS_ZERO;
    else if (grayscale_count_clock_rise && gs_count != GS_MAX)
      gs_count <= gs_count + 12'h001;
  end

  // ****************************************
  // Per-channel compare, drive and open detect
  // ****************************************
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ch
    logic [GS_W-1:0]     grayscale_value;
    logic [SETTLE_W-1:0] settle;

    assign grayscale_value = gs_active[ch*GS_W +: GS_W];
    assign gs_zero[ch]     = (grayscale_value == GS_ZERO);

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
      if (!RST_N)
        ch_on[ch] <= 1'b0;
      else if (inh_s)
        ch_on[ch] <= 1'b0;
      else if (grayscale_count_clock_rise)
      begin
        if (gs_count == GS_ZERO)
          ch_on[ch] <= ~gs_zero[ch];
        else if (gs_count == grayscale_value)
          ch_on[ch] <= 1'b0;
      end
    end

    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
      if (!RST_N)
        settle <= '0;
      else if (!ch_on[ch])
        settle <= '0;
      else if (settle != SETTLE_LAST)
        settle <= settle + 6'h01;
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
      if (!RST_N)
        open_led_flag[ch] <= 1'b0;
      else if (ch_on[ch] && !inh_s && settle == SETTLE_LAST && open_s[ch])
        open_led_flag[ch] <= 1'b1;
      else if (open_clr && AVS_WRITEDATA[ST_OPEN_LSB + ch])
        open_led_flag[ch] <= 1'b0;
    end
  end

  assign SINK_CHANNEL = ch_on;

  // ****************************************
  // Avalon-MM slave: one wait state per access
  // ****************************************
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~resp;
  assign wr_take         = AVS_WRITE & resp;
  assign open_clr        = wr_take && AVS_ADDRESS == REG_STATUS
                           && AVS_BYTEENABLE[BE_W-1:BE_W-2] == 2'h3;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      resp <= 1'b0;
    else
      resp <= (AVS_READ | AVS_WRITE) & ~resp;
  end

  always_comb
  begin
    next_readdata = '0;
    case (AVS_ADDRESS)
      REG_STATUS:
      begin
        next_readdata[ST_CNT_LSB +: GS_W]    = gs_count;
        next_readdata[ST_OTEMP]              = overtemp_flag;
        next_readdata[ST_MODE]               = prog_s;
        next_readdata[ST_PENDING]            = gs_pending;
        next_readdata[ST_OPEN_LSB +: NUM_CH] = open_led_flag;
      end
      REG_NVCORR0: next_readdata = nv_corr[0];
      REG_NVCORR1: next_readdata = nv_corr[1];
      REG_NVCORR2: next_readdata = nv_corr[2];
      REG_CORR0:   next_readdata = corr_reg[DATA_W-1:0];
      REG_CORR1:   next_readdata = corr_reg[2*DATA_W-1:DATA_W];
      REG_CORR2:   next_readdata = corr_reg[3*DATA_W-1:2*DATA_W];
      default:     next_readdata = '0;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      AVS_READDATA <= '0;
    else if (AVS_READ && !resp)
      AVS_READDATA <= next_readdata;
  end

  // Stored correction words, byte-lane writable
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      nv_corr <= {NVCORR_WORDS{NVCORR_RST}};
    else if (wr_take)
    begin
      for (int w = 0; w < NVCORR_WORDS; w++)
      begin
        if (AVS_ADDRESS == REG_NVCORR0 + ADDR_W'(4 * w))
        begin
          for (int b = 0; b < BE_W; b++)
          begin
            if (AVS_BYTEENABLE[b])
              nv_corr[w][8*b +: 8] <= AVS_WRITEDATA[8*b +: 8];
          end
        end
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  AST_INHIBIT_OFF: assert property (
    inh_s |=> (ch_on == '0) && (gs_count == GS_ZERO))
    else $error("channels or counter active under inhibit");

  AST_ZERO_OFF: assert property (
    (ch_on & gs_zero & ~$past(ch_on)) == '0)
    else $error("zero-valued channel switched on");

  AST_FIRST_COUNT: assert property (
    grayscale_count_clock_rise && !inh_s && gs_count == GS_ZERO
    |=> gs_count == 12'h001 && (ch_on == ~$past(gs_zero)))
    else $error("first count clock did not start the cycle");

  AST_COUNT_STEP: assert property (
    grayscale_count_clock_rise && !inh_s && gs_count != GS_MAX
    |=> gs_count == $past(gs_count) + 12'h001)
    else $error("counter did not advance by one");

  AST_MATCH_OFF: assert property (
    grayscale_count_clock_rise && !inh_s && gs_count != GS_ZERO
    && gs_count == gs_active[GS_W +: GS_W] |=> !ch_on[1])
    else $error("channel not switched off at matching count");

  AST_GS_LATCH: assert property (
    latch_rise && !prog_s && !need_extra |=> gs_active == $past(shift_reg))
    else $error("grayscale latch did not take the shift register");

  AST_STATUS_LOAD: assert property (
    latch_rise && !prog_s |=> shift_reg[GS_PKT_W-1:OPEN_LSB] == $past(open_led_flag)
    && shift_reg[OVERTEMP_BIT] == $past(overtemp_flag) && shift_reg[CORR_LSB-1:0] == '0)
    else $error("status word not loaded after latch");

  AST_CORR_SRC: assert property (
    latch_rise && !prog_s && csrc_s |=> shift_reg[CORR_MSB:CORR_LSB] == $past(corr_reg))
    else $error("correction field does not follow source select");

  AST_DC_LATCH: assert property (
    latch_rise && prog_s |=> corr_reg == $past(shift_reg[DC_PKT_W-1:0]) ##1 need_extra)
    else $error("correction latch failed");

  AST_EXTRA_CLK: assert property (
    gs_pending && sclk_rise && !latch_rise |=> !gs_pending && gs_active == $past(gs_input))
    else $error("extra shift clock did not complete update");

  AST_SHIFT_IN: assert property (
    sclk_rise && !latch_rise && !prog_s
    |=> shift_reg == {$past(shift_reg[GS_PKT_W-2:0]), $past(sin_s)} ##1
        SERIAL_OUTPUT_PIN == shift_reg[GS_PKT_W-1] || prog_s)
    else $error("shift register did not advance");

  AST_OPEN_SET: assert property (
    $rose(open_led_flag[2]) |-> !$past(inh_s) && $past(ch_on[2]) && $past(open_s[2])
    && $past(g_ch[2].settle) == SETTLE_LAST)
    else $error("open flag set outside its window");

endmodule : grayscale_pwm_led_channels

// ### sim/display_ctrl_model.sv
// Controller model that drives the serial link and the PWM pins
`timescale 1ns/10ps
module display_ctrl_model
(
  // Clock
  input  wire logic clk,
  // Link pins
  input  wire logic serial_output_pin,
  output logic      sclk,
  output logic      serial_input_pin,
  output logic      latch,
  // PWM pins
  output logic      grayscale_count_clock,
  output logic      inh
);
  initial
  begin
    sclk  = 1'b0;
    serial_input_pin   = 1'b0;
    latch = 1'b0;
    grayscale_count_clock = 1'b0;
    inh   = 1'b1;
  end

  // Shift clock stands low between frames; 4 cycles high, 4 low is 200 ns
  task automatic shift_bits(input int n, input logic [191:0] din,
                            output logic [191:0] dout);
    dout = '0;
    @(posedge clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_input_pin <= din[i];
      repeat (4) @(posedge clk);
      // Serial output is taken just before the shift clock rises
      dout[i] = serial_output_pin;
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      sclk <= 1'b0;
    end
    @(posedge clk);
    serial_input_pin <= ~din[0];
  endtask : shift_bits

  task automatic pulse_latch();
    @(posedge clk);
    latch <= 1'b1;
    repeat (4) @(posedge clk);
    latch <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : pulse_latch

  task automatic pulse_grayscale_count_clock();
    @(posedge clk);
    grayscale_count_clock <= 1'b1;
    repeat (3) @(posedge clk);
    grayscale_count_clock <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse_grayscale_count_clock

  task automatic set_inhibit(input logic v);
    @(posedge clk);
    inh <= v;
    repeat (6) @(posedge clk);
  endtask : set_inhibit
endmodule : display_ctrl_model

// ### sim/grayscale_pwm_led_channels_test.sv
// Self-checking bench for the grayscale PWM channel block
`timescale 1ns/10ps
module grayscale_pwm_led_channels_test;
  import gs_pwm_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic              ref_clk, rst_n, read, write, wreq;
  logic [ADDR_W-1:0] address;
  logic [BE_W-1:0]   byteenable;
  logic [DATA_W-1:0] writedata, readdata, rd;
  logic              sclk, serial_input_pin, latch, serial_output_pin, prog, csrc, grayscale_count_clock, inh, otemp;
  logic [NUM_CH-1:0] sink, open_sense;
  logic [GS_W-1:0]   gsv [NUM_CH];
  logic [DATA_W-1:0] nv [3];
  logic [95:0]       corr;
  logic [191:0]      dout;
  int                seed, error_cnt, check_count;
  int                cycles = 0;

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  grayscale_pwm_led_channels u_dut
  (
    .REF_CLK                  (ref_clk),
    .RST_N                    (rst_n),
    .AVS_ADDRESS              (address),
    .AVS_READ                 (read),
    .AVS_WRITE                (write),
    .AVS_BYTEENABLE           (byteenable),
    .AVS_WRITEDATA            (writedata),
    .AVS_READDATA             (readdata),
    .AVS_WAITREQUEST          (wreq),
    .SERIAL_SHIFT_CLOCK       (sclk),
    .SERIAL_INPUT_PIN         (serial_input_pin),
    .LATCH_STROBE             (latch),
    .SERIAL_OUTPUT_PIN        (serial_output_pin),
    .PROGRAM_SELECT_PIN       (prog),
    .CORRECTION_SOURCE_SELECT (csrc),
    .GRAYSCALE_COUNT_CLOCK    (grayscale_count_clock),
    .OUTPUT_INHIBIT           (inh),
    .SINK_CHANNEL             (sink),
    .OPEN_SENSE               (open_sense),
    .OVERTEMP_SENSE           (otemp)
  );

  display_ctrl_model u_ctrl
  (
    .clk   (ref_clk),
    .serial_output_pin  (serial_output_pin),
    .sclk  (sclk),
    .serial_input_pin   (serial_input_pin),
    .latch (latch),
    .grayscale_count_clock (grayscale_count_clock),
    .inh   (inh)
  );

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic test_done();
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [191:0] got, input logic [191:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [BE_W-1:0] be);
    int n;
    n = 0;
    @(posedge ref_clk);
    address    <= a;
    read       <= ~wr;
    write      <= wr;
    writedata  <= d;
    byteenable <= be;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    rd = readdata;
    if (n >= 50)
      error_cnt++;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  function automatic logic [NUM_CH-1:0] exp_sink(int k);
    logic [NUM_CH-1:0] s;
    for (int c = 0; c < NUM_CH; c++)
      s[c] = (k >= 1) && (k <= int'(gsv[c]));
    return s;
  endfunction : exp_sink

  function automatic logic [191:0] exp_status(logic [15:0] op, logic ot, logic [95:0] cv);
    logic [191:0] s;
    s = '0;
    s[OPEN_LSB +: NUM_CH] = op;
    s[OVERTEMP_BIT] = ot;
    s[CORR_LSB +: 96] = cv;
    return s;
  endfunction : exp_status

  function automatic logic [191:0] pack_gs();
    logic [191:0] p;
    for (int c = 0; c < NUM_CH; c++)
      p[GS_W*c +: GS_W] = gsv[c];
    return p;
  endfunction : pack_gs

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    seed = 32'hA7D2;
    error_cnt = 0;
    check_count = 0;
    {rst_n, read, write, prog, csrc, otemp} = 6'h00;
    {address, byteenable, writedata, open_sense} = '0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("sink", sink, 0);
    chk("serial_output_pin", serial_output_pin, 0);
    bus(0, REG_STATUS, 0, 4'hF);
    chk("status", rd, 0);
    bus(1, 8'h40, $random(seed), 4'hF);
    bus(0, 8'h40, 0, 4'hF);
    chk("unmapped", rd, 0);
    for (int w = 0; w < NVCORR_WORDS; w++)
    begin
      nv[w] = $random(seed);
      bus(1, REG_NVCORR0 + ADDR_W'(4 * w), nv[w], 4'hF);
      bus(0, REG_NVCORR0 + ADDR_W'(4 * w), 0, 4'hF);
      chk("nvcorr", rd, nv[w]);
    end
    bus(1, REG_CORR0, 32'hFFFF_FFFF, 4'hF);
    bus(0, REG_CORR0, 0, 4'hF);
    chk("corr ro", rd, 0);
    // Correction load, then first grayscale latch waits for one extra shift clock
    prog <= 1'b1;
    repeat (4) @(posedge ref_clk);
    bus(0, REG_STATUS, 0, 4'hF);
    chk("mode", rd, 32'h0000_2000);
    corr = {$random(seed), $random(seed), $random(seed)};
    u_ctrl.shift_bits(96, {96'h0, corr}, dout);
    u_ctrl.pulse_latch();
    for (int w = 0; w < 3; w++)
    begin
      bus(0, REG_CORR0 + ADDR_W'(4 * w), 0, 4'hF);
      chk("corr", rd, corr[32*w +: 32]);
    end
    prog <= 1'b0;
    repeat (4) @(posedge ref_clk);
    for (int c = 0; c < NUM_CH; c++)
      gsv[c] = GS_W'($random(seed));
    gsv[0] = GS_ZERO;
    gsv[1] = 12'h001;
    gsv[2] = GS_MAX;
    gsv[3] = 12'hFFE;
    u_ctrl.shift_bits(192, pack_gs(), dout);
    u_ctrl.pulse_latch();
    bus(0, REG_STATUS, 0, 4'hF);
    chk("pending", rd[ST_PENDING], 1);
    u_ctrl.shift_bits(1, 192'h1, dout);
    bus(0, REG_STATUS, 0, 4'hF);
    chk("pending", rd[ST_PENDING], 0);
    // Full PWM cycle with open sensing on a short, a long and an unlit channel
    open_sense <= 16'h0007;
    otemp <= 1'b1;
    u_ctrl.set_inhibit(1'b0);
    chk("sink", sink, 0);
    for (int k = 1; k <= 4096; k++)
    begin
      u_ctrl.pulse_grayscale_count_clock();
      chk("sink", sink, exp_sink(k));
      if (k == 1)
      begin
        bus(0, REG_STATUS, 0, 4'hF);
        chk("count", rd[11:0], 1);
      end
    end
    bus(0, REG_STATUS, 0, 4'hF);
    chk("count", rd[11:0], 12'hFFF);
    chk("open", rd[31:16], 16'h0004);
    chk("otemp", rd[ST_OTEMP], 1);
    u_ctrl.set_inhibit(1'b1);
    u_ctrl.pulse_grayscale_count_clock();
    chk("sink", sink, 0);
    bus(1, REG_STATUS, 32'hFFFF_0000, 4'h3);
    bus(0, REG_STATUS, 0, 4'hF);
    chk("count", rd[11:0], 0);
    chk("open", rd[31:16], 16'h0004);
    // Status word read back with both correction sources
    for (int s = 0; s < 2; s++)
    begin
      csrc <= s[0];
      repeat (4) @(posedge ref_clk);
      u_ctrl.pulse_latch();
      u_ctrl.shift_bits(192, pack_gs(), dout);
      chk("status word", dout,
          exp_status(16'h0004, 1'b1, s ? corr : {nv[2], nv[1], nv[0]}));
    end
    open_sense <= '0;
    bus(1, REG_STATUS, 32'hFFFF_0000, 4'hC);
    bus(0, REG_STATUS, 0, 4'hF);
    chk("open", rd[31:16], 0);
    test_done();
  end
endmodule : grayscale_pwm_led_channels_test
